// File: verilog/mtfc_tx_ctrl.v
// transmit gap, back-off, pause flow control and backpressure of the mac
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "mtfc_defs.vh"

module mtfc_tx_ctrl (
	input wire i_mclk, // 25 MHz clock
	input wire i_nrst, // synchronous reset, active low
	input wire [7:0] i_addr, // register byte address
	input wire [15:0] i_wdata, // register write data
	input wire i_wr, // write strobe
	input wire i_rd, // read strobe
	output reg [15:0] o_rdata, // read data, cycle after i_rd
	input wire i_crs, // carrier sense pin from phy
	input wire i_col, // collision pin from phy
	input wire [15:0] i_rxq_free, // free bytes in receive queue
	input wire i_rx_pause_valid, // pause frame received, pulse
	input wire [15:0] i_rx_pause_time, // received pause quanta
	input wire i_txq_pend, // normal frame queued, level
	input wire i_tx_end, // frame sent without collision, pulse
	output reg o_tx_go, // start a frame, pulse
	output reg o_tx_is_pause, // frame started is a pause frame
	output reg [15:0] o_tx_pause_time, // pause time of that frame
	output reg o_tx_abort, // stop and jam current frame, pulse
	output reg o_tx_drop, // normal frame abandoned, pulse
	output reg o_bp_carrier, // send preamble for backpressure
	output reg o_rx_drop // discard incoming frames
);

// ----------------------------------------
// states
// ----------------------------------------
localparam ST_IDLE = 2'd0;
localparam ST_TX = 2'd1;
localparam ST_BACKOFF = 2'd2;
localparam ST_BP = 2'd3;

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
reg crs_m_reg;
reg crs_s_reg;
reg col_m_reg;
reg col_s_reg;
always @(posedge i_mclk) begin
	if (!i_nrst) begin
		crs_m_reg <= 1'b0;
		crs_s_reg <= 1'b0;
		col_m_reg <= 1'b0;
		col_s_reg <= 1'b0;
	end else begin
		crs_m_reg <= i_crs;
		crs_s_reg <= crs_m_reg;
		col_m_reg <= i_col;
		col_s_reg <= col_m_reg;
	end
end

// ----------------------------------------
// registers
// ----------------------------------------
reg [15:0] low_wm_reg;
reg [15:0] high_wm_reg;
reg [15:0] ovr_wm_reg;
reg [15:0] ctrl_reg;
reg paused_reg;
reg xoff_reg;
reg [4:0] coll_reg;
reg [1:0] state_reg;

wire fdx = ctrl_reg[`MTFC_CTRL_FDX];
wire spd100 = ctrl_reg[`MTFC_CTRL_SPD100];
wire bp_en = ctrl_reg[`MTFC_CTRL_BP_EN];

always @(posedge i_mclk) begin
	if (!i_nrst) begin
		low_wm_reg <= `MTFC_RST_LOW_WM;
		high_wm_reg <= `MTFC_RST_HIGH_WM;
		ovr_wm_reg <= `MTFC_RST_OVR_WM;
		ctrl_reg <= `MTFC_RST_CTRL;
	end else if (i_wr) begin
		case (i_addr)
			`MTFC_OFF_LOW_WM: low_wm_reg <= i_wdata;
			`MTFC_OFF_HIGH_WM: high_wm_reg <= i_wdata;
			`MTFC_OFF_OVR_WM: ovr_wm_reg <= i_wdata;
			`MTFC_OFF_CTRL: ctrl_reg <= {13'h0000, i_wdata[2:0]};
			default: ;
		endcase
	end
end

always @(posedge i_mclk) begin
	if (!i_nrst) begin
		o_rdata <= 16'h0000;
	end else if (i_rd) begin
		case (i_addr)
			`MTFC_OFF_LOW_WM: o_rdata <= low_wm_reg;
			`MTFC_OFF_HIGH_WM: o_rdata <= high_wm_reg;
			`MTFC_OFF_OVR_WM: o_rdata <= ovr_wm_reg;
			`MTFC_OFF_CTRL: o_rdata <= ctrl_reg;
			`MTFC_OFF_STAT: o_rdata <= {7'h00, coll_reg, o_rx_drop, o_bp_carrier,
				xoff_reg, paused_reg};
			default: o_rdata <= 16'h0000;
		endcase
	end else begin
		o_rdata <= 16'h0000;
	end
end

// ----------------------------------------
// nibble-time enable
// ----------------------------------------
// one pulse per 4 bit times: every cycle at 100M, every 10 at 10M
reg [3:0] div_reg;
wire nib_en = spd100 ? 1'b1 : (div_reg == 4'h0);
always @(posedge i_mclk) begin
	if (!i_nrst || spd100 || div_reg == 4'h0) begin
		div_reg <= `MTFC_NIB_RELOAD;
	end else begin
		div_reg <= div_reg - 4'h1;
	end
end

// ----------------------------------------
// receive queue watermarks
// ----------------------------------------
reg xon_req_reg;
reg xoff_req_reg;
wire hit_high = (i_rxq_free <= high_wm_reg);
wire hit_low = (i_rxq_free >= low_wm_reg);
wire pause_sent = o_tx_go && o_tx_is_pause;
always @(posedge i_mclk) begin
	if (!i_nrst) begin
		xoff_reg <= 1'b0;
		xoff_req_reg <= 1'b0;
		xon_req_reg <= 1'b0;
		o_rx_drop <= 1'b0;
	end else begin
		o_rx_drop <= (i_rxq_free <= ovr_wm_reg);
		if (!xoff_reg && hit_high) begin
			xoff_reg <= 1'b1;
			xoff_req_reg <= fdx;
			xon_req_reg <= 1'b0;
		end else if (xoff_reg && hit_low) begin
			xoff_reg <= 1'b0;
			xon_req_reg <= fdx;
			xoff_req_reg <= 1'b0;
		end else if (pause_sent) begin
			xoff_req_reg <= 1'b0;
			xon_req_reg <= 1'b0;
		end
	end
end

// ----------------------------------------
// received pause timer
// ----------------------------------------
reg [15:0] quanta_reg;
reg [6:0] qnib_reg;
always @(posedge i_mclk) begin
	if (!i_nrst) begin
		quanta_reg <= 16'h0000;
		qnib_reg <= 7'h00;
		paused_reg <= 1'b0;
	end else if (i_rx_pause_valid && fdx) begin
		quanta_reg <= i_rx_pause_time;
		qnib_reg <= 7'h00;
		paused_reg <= (i_rx_pause_time != 16'h0000);
	end else if (paused_reg && nib_en) begin
		qnib_reg <= qnib_reg + 7'h01;
		if (qnib_reg == `MTFC_SLOT_LAST) begin
			quanta_reg <= quanta_reg - 16'h0001;
			if (quanta_reg == 16'h0001) begin
				paused_reg <= 1'b0;
			end
		end
	end
end

// ----------------------------------------
// inter packet gap
// ----------------------------------------
reg [4:0] ipg_reg;
wire ipg_ok = (ipg_reg == `MTFC_IPG_DONE);
always @(posedge i_mclk) begin
	if (!i_nrst || state_reg == ST_TX || o_bp_carrier) begin
		ipg_reg <= 5'h00;
	end else if (crs_s_reg && !fdx) begin
		ipg_reg <= 5'h00;
	end else if (nib_en && !ipg_ok) begin
		ipg_reg <= ipg_reg + 5'h01;
	end
end

// ----------------------------------------
// transmit control
// ----------------------------------------
reg [15:0] lfsr_reg;
reg [7:0] fnib_reg;
reg [6:0] snib_reg;
reg [9:0] slots_reg;
reg [12:0] bp_cnt_reg;
reg bp_gap_reg;
reg cur_pause_reg;

wire bp_want = bp_en && !fdx && xoff_reg;
wire pause_pend = xoff_req_reg || xon_req_reg;
wire medium_free = ipg_ok && (fdx || !crs_s_reg);
wire late = (fnib_reg >= `MTFC_LATE_NIB);
// exponent counts the collision in hand, so the first retry picks 0 or 1 slot
wire [3:0] bo_exp = (coll_reg >= `MTFC_BO_CAP_COLL) ? `MTFC_BO_EXP_MAX : coll_reg[3:0] + 4'h1;
wire [10:0] bo_span = (11'h001 << bo_exp) - 11'h001;
wire [9:0] bo_mask = bo_span[9:0];

always @(posedge i_mclk) begin
	if (!i_nrst) begin
		lfsr_reg <= 16'hace1;
	end else begin
		lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
	end
end

always @(posedge i_mclk) begin
	if (!i_nrst) begin
		state_reg <= ST_IDLE;
		coll_reg <= 5'h00;
		fnib_reg <= 8'h00;
		snib_reg <= 7'h00;
		slots_reg <= 10'h000;
		bp_cnt_reg <= 13'h0000;
		bp_gap_reg <= 1'b0;
		cur_pause_reg <= 1'b0;
		o_tx_go <= 1'b0;
		o_tx_is_pause <= 1'b0;
		o_tx_pause_time <= 16'h0000;
		o_tx_abort <= 1'b0;
		o_tx_drop <= 1'b0;
		o_bp_carrier <= 1'b0;
	end else begin
		o_tx_go <= 1'b0;
		o_tx_abort <= 1'b0;
		o_tx_drop <= 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (medium_free && pause_pend) begin
					o_tx_go <= 1'b1;
					o_tx_is_pause <= 1'b1;
					o_tx_pause_time <= xoff_req_reg ? `MTFC_PAUSE_MAX : `MTFC_PAUSE_ZERO;
					cur_pause_reg <= 1'b1;
					fnib_reg <= 8'h00;
					state_reg <= ST_TX;
				end else if (medium_free && i_txq_pend && !paused_reg) begin
					o_tx_go <= 1'b1;
					o_tx_is_pause <= 1'b0;
					o_tx_pause_time <= `MTFC_PAUSE_ZERO;
					cur_pause_reg <= 1'b0;
					fnib_reg <= 8'h00;
					state_reg <= ST_TX;
				end else if (bp_want && !i_txq_pend && medium_free) begin
					o_bp_carrier <= 1'b1;
					bp_cnt_reg <= 13'h0000;
					bp_gap_reg <= 1'b0;
					state_reg <= ST_BP;
				end
			end
			ST_TX: begin
				if (nib_en && !late) begin
					fnib_reg <= fnib_reg + 8'h01;
				end
				if (i_tx_end) begin
					coll_reg <= 5'h00;
					state_reg <= ST_IDLE;
				end else if (col_s_reg && !fdx) begin
					o_tx_abort <= 1'b1;
					if (late) begin
						o_tx_drop <= !cur_pause_reg;
						coll_reg <= 5'h00;
						state_reg <= ST_IDLE;
					end else if (coll_reg == `MTFC_LAST_COLL) begin
						o_tx_drop <= !cur_pause_reg;
						coll_reg <= 5'h00;
						state_reg <= ST_IDLE;
					end else begin
						coll_reg <= coll_reg + 5'h01;
						slots_reg <= lfsr_reg[9:0] & bo_mask;
						snib_reg <= 7'h00;
						state_reg <= ST_BACKOFF;
					end
				end
			end
			ST_BACKOFF: begin
				// retry waits slots, then the normal idle path also enforces the gap
				if (slots_reg == 10'h000) begin
					state_reg <= ST_IDLE;
				end else if (nib_en) begin
					snib_reg <= snib_reg + 7'h01;
					if (snib_reg == `MTFC_SLOT_LAST) begin
						slots_reg <= slots_reg - 10'h001;
					end
				end
			end
			ST_BP: begin
				if (!bp_want || i_txq_pend || pause_pend) begin
					o_bp_carrier <= 1'b0;
					state_reg <= ST_IDLE;
				end else if (!bp_gap_reg) begin
					// a collision here is ignored: no back-off, carrier held
					o_bp_carrier <= 1'b1;
					bp_cnt_reg <= bp_cnt_reg + 13'h0001;
					if (bp_cnt_reg == `MTFC_BP_ON_LAST) begin
						o_bp_carrier <= 1'b0;
						bp_gap_reg <= 1'b1;
						bp_cnt_reg <= 13'h0000;
					end
				end else begin
					bp_cnt_reg <= bp_cnt_reg + 13'h0001;
					if (bp_cnt_reg == `MTFC_BP_GAP_LAST) begin
						o_bp_carrier <= 1'b1;
						bp_gap_reg <= 1'b0;
						bp_cnt_reg <= 13'h0000;
					end
				end
			end
			default: state_reg <= ST_IDLE;
		endcase
	end
end

endmodule
`default_nettype wire

// File: pkg/mtfc_defs.vh
// constants for the transmit flow control block
`ifndef MTFC_DEFS_VH
`define MTFC_DEFS_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define MTFC_OFF_LOW_WM 8'hb0
`define MTFC_OFF_HIGH_WM 8'hb2
`define MTFC_OFF_OVR_WM 8'hb4
`define MTFC_OFF_CTRL 8'hb6
`define MTFC_OFF_STAT 8'hb8

// ----------------------------------------
// reset values (watermarks in free bytes of the receive queue, then control)
// ----------------------------------------
`define MTFC_RST_LOW_WM 16'h1400
`define MTFC_RST_HIGH_WM 16'h0c00
`define MTFC_RST_OVR_WM 16'h0100
`define MTFC_RST_CTRL 16'h0003

// ----------------------------------------
// control and status fields
// ----------------------------------------
`define MTFC_CTRL_FDX 0
`define MTFC_CTRL_SPD100 1
`define MTFC_CTRL_BP_EN 2
`define MTFC_STAT_PAUSED 0
`define MTFC_STAT_XOFF 1
`define MTFC_STAT_BP 2
`define MTFC_STAT_RXDROP 3
`define MTFC_STAT_COLL_LSB 4

// ----------------------------------------
// timing
// ----------------------------------------
`define MTFC_CLK_NS 40
`define MTFC_NIB_CYC_100 1
`define MTFC_NIB_CYC_10 10
`define MTFC_IPG_BITS 96
`define MTFC_IPG_NIB (`MTFC_IPG_BITS / 4)
`define MTFC_SLOT_BITS 512
`define MTFC_SLOT_NIB (`MTFC_SLOT_BITS / 4)
`define MTFC_MAX_COLL 16
`define MTFC_BO_LIMIT 10
`define MTFC_PAUSE_MAX 16'hffff
`define MTFC_PAUSE_ZERO 16'h0000
`define MTFC_BP_ON_NS 100000
`define MTFC_BP_ON_CYC (`MTFC_BP_ON_NS / `MTFC_CLK_NS)
`define MTFC_BP_GAP_NS 1000
`define MTFC_BP_GAP_CYC (`MTFC_BP_GAP_NS / `MTFC_CLK_NS)
// sized end points of the counters above, kept in step with them by hand
`define MTFC_NIB_RELOAD 4'h9
`define MTFC_IPG_DONE 5'h18
`define MTFC_SLOT_LAST 7'h7f
`define MTFC_LATE_NIB 8'h80
`define MTFC_LAST_COLL 5'h0f
`define MTFC_BO_CAP_COLL 5'h09
`define MTFC_BO_EXP_MAX 4'ha
`define MTFC_BP_ON_LAST 13'h09c3
`define MTFC_BP_GAP_LAST 13'h0018

`endif

// File: tb/mtfc_tx_ctrl_checker.sv
// port assertions of the transmit flow control block
`timescale 1ns/1ps
`default_nettype none
`include "mtfc_defs.vh"
module mtfc_tx_ctrl_chk (
	input wire logic i_mclk, // clock
	input wire logic i_nrst, // reset
	input wire logic [7:0] i_addr, // address
	input wire logic [15:0] i_wdata, // wdata
	input wire logic i_wr, // write
	input wire logic i_col, // collision
	input wire logic [15:0] i_rxq_free, // free bytes
	input wire logic i_rx_pause_valid, // pause in
	input wire logic [15:0] i_rx_pause_time, // quanta
	input wire logic i_txq_pend, // queued
	input wire logic i_tx_end, // frame end
	input wire logic o_tx_go, // start
	input wire logic o_tx_is_pause, // pause kind
	input wire logic [15:0] o_tx_pause_time, // pause time
	input wire logic o_tx_abort, // abort
	input wire logic o_tx_drop, // drop
	input wire logic o_bp_carrier, // carrier
	input wire logic o_rx_drop // rx discard
);
// ----
// shadow state
// ----
logic [15:0] ovr_reg;
logic [7:0] gap_reg;
logic [23:0] hold_reg;
logic [11:0] bp_reg;
always @(posedge i_mclk) begin
	if (!i_nrst) begin
		ovr_reg <= `MTFC_RST_OVR_WM;
		gap_reg <= 8'hff;
		hold_reg <= 24'h0;
		bp_reg <= 12'h0;
	end else begin
		if (i_wr && i_addr == `MTFC_OFF_OVR_WM)
			ovr_reg <= i_wdata;
		if (i_tx_end)
			gap_reg <= 8'h0;
		else if (gap_reg != 8'hff)
			gap_reg <= gap_reg + 8'h1;
		// quanta at 100 Mb/s, only a lower bound at 10 Mb/s
		if (i_rx_pause_valid)
			hold_reg <= {1'b0, i_rx_pause_time, 7'h0};
		else if (hold_reg != 24'h0)
			hold_reg <= hold_reg - 24'h1;
		bp_reg <= o_bp_carrier ? bp_reg + 12'h1 : 12'h0;
	end
end
default clocking dc @(posedge i_mclk); endclocking
default disable iff (!i_nrst);
sequence s_flow_go;
	o_tx_go && o_tx_is_pause;
endsequence
// one cycle of slack for the registered start
a_ipg_gap: assert property (o_tx_go |-> gap_reg >= 8'd23)
	else $error("frame started inside the gap");
a_pause_hold: assert property (hold_reg > 1 && $past(hold_reg) > 1 |->
	!(o_tx_go && !o_tx_is_pause)) else $error("normal frame while paused");
a_pause_val: assert property (s_flow_go |-> o_tx_pause_time inside {16'hffff, 16'h0})
	else $error("bad pause time");
a_rx_over: assert property ($past(i_nrst) |-> o_rx_drop == $past(i_rxq_free <= ovr_reg))
	else $error("rx drop wrong");
a_drop_abort: assert property (o_tx_drop |-> o_tx_abort)
	else $error("drop without abort");
// pin pulse, two synchroniser stages, then the registered abort
a_abort_cause: assert property (o_tx_abort |-> $past(i_col, 3))
	else $error("abort without collision");
a_bp_period: assert property (bp_reg <= 12'd2500)
	else $error("carrier held too long");
a_bp_yield: assert property ($past(i_txq_pend) && $past(i_txq_pend, 2) |-> !o_bp_carrier)
	else $error("carrier kept with frame queued");
endmodule
bind mtfc_tx_ctrl mtfc_tx_ctrl_chk mtfc_tx_ctrl_chk_inst (.i_mclk(i_mclk), .i_nrst(i_nrst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_col(i_col), .i_rxq_free(i_rxq_free),
	.i_rx_pause_valid(i_rx_pause_valid), .i_rx_pause_time(i_rx_pause_time),
	.i_txq_pend(i_txq_pend), .i_tx_end(i_tx_end), .o_tx_go(o_tx_go),
	.o_tx_is_pause(o_tx_is_pause), .o_tx_pause_time(o_tx_pause_time), .o_tx_abort(o_tx_abort),
	.o_tx_drop(o_tx_drop), .o_bp_carrier(o_bp_carrier), .o_rx_drop(o_rx_drop));
`default_nettype wire

// File: tb/mtfc_peer.sv
// far station model: ends or collides each frame the mac starts
`timescale 1ns/1ps
`default_nettype none
module mtfc_peer (
	input wire logic i_mclk, // clock
	input wire logic i_go, // frame start
	input wire logic i_abort, // frame jammed
	input wire logic [7:0] i_len, // frame cycles
	input wire logic [7:0] i_col_at, // collide here, 0 none
	output logic o_crs = 1'b0, // carrier
	output logic o_col = 1'b0, // collision
	output logic o_end = 1'b0 // clean end
);
logic [7:0] cnt_reg = 8'h0;
always @(posedge i_mclk) begin
	o_end <= 1'b0;
	o_col <= 1'b0;
	cnt_reg <= cnt_reg + 8'h1;
	if (i_go) begin
		o_crs <= 1'b1;
		cnt_reg <= 8'h0;
	end else if (i_abort || (o_crs && cnt_reg == i_len)) begin
		o_crs <= 1'b0;
		o_end <= !i_abort;
	end else if (o_crs && i_col_at != 8'h0 && cnt_reg == i_col_at)
		o_col <= 1'b1;
end
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench of the transmit flow control block
`timescale 1ns/1ps
`default_nettype none
module tb;
logic i_mclk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
logic i_rx_pause_valid = 1'b0, i_txq_pend = 1'b0;
logic [7:0] i_addr = 8'h0, len = 8'h40, col_at = 8'h0;
logic [15:0] i_wdata = 16'h0, i_rxq_free = 16'hffff, i_rx_pause_time = 16'h0;
logic [15:0] o_rdata, o_tx_pause_time;
logic crs, col, tx_end, o_tx_go, o_tx_is_pause, o_tx_abort, o_tx_drop, o_bp_carrier, o_rx_drop;
int n_fail = 0, samples_checked = 0, n_go = 0, n_drop = 0, n_abt = 0, n, k, g;
always #20 i_mclk = ~i_mclk;
always @(posedge i_mclk) begin
	n_go <= n_go + int'(o_tx_go === 1'b1);
	n_drop <= n_drop + int'(o_tx_drop === 1'b1);
	n_abt <= n_abt + int'(o_tx_abort === 1'b1);
end
mtfc_tx_ctrl mtfc_tx_ctrl_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_crs(crs), .i_col(col),
	.i_rxq_free(i_rxq_free), .i_rx_pause_valid(i_rx_pause_valid),
	.i_rx_pause_time(i_rx_pause_time), .i_txq_pend(i_txq_pend), .i_tx_end(tx_end),
	.o_tx_go(o_tx_go), .o_tx_is_pause(o_tx_is_pause), .o_tx_pause_time(o_tx_pause_time),
	.o_tx_abort(o_tx_abort), .o_tx_drop(o_tx_drop), .o_bp_carrier(o_bp_carrier),
	.o_rx_drop(o_rx_drop));
mtfc_peer mtfc_peer_inst (.i_mclk(i_mclk), .i_go(o_tx_go), .i_abort(o_tx_abort), .i_len(len),
	.i_col_at(col_at), .o_crs(crs), .o_col(col), .o_end(tx_end));
task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
	samples_checked++;
	if (got !== exp) begin
		$display("unexpected %s: expected %h, seen %h", what, exp, got);
		n_fail++;
	end
endtask
task cyc(input int c);
	repeat (c) @(posedge i_mclk);
endtask
task wr(input logic [7:0] a, input logic [15:0] d);
	cyc(1);
	i_wr <= 1'b1;
	i_addr <= a;
	i_wdata <= d;
	cyc(1);
	i_wr <= 1'b0;
endtask
task rd(input logic [7:0] a, input logic [15:0] exp, input string what);
	cyc(1);
	i_rd <= 1'b1;
	i_addr <= a;
	cyc(1);
	i_rd <= 1'b0;
	#1 chk(what, exp, o_rdata);
endtask
task wait_go;
	n = 0;
	do begin
		cyc(1);
		#1 n++;
	end while (o_tx_go !== 1'b1 && n < 4000);
	if (n >= 4000)
		chk("frame start", 16'h1, 16'h0);
endtask
task pause_in(input logic [15:0] q);
	i_rx_pause_time <= q;
	i_rx_pause_valid <= 1'b1;
	cyc(1);
	i_rx_pause_valid <= 1'b0;
endtask
task final_report;
	$display("checks %0d, mismatches %0d", samples_checked, n_fail);
	if (n_fail == 0 && samples_checked > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask
initial begin
	#1200000;
	n_fail++;
	final_report;
end
initial begin
	cyc(4);
	i_nrst <= 1'b1;
	rd(8'hb0, 16'h1400, "low watermark");
	rd(8'hb2, 16'h0c00, "high watermark");
	rd(8'hb4, 16'h0100, "overrun watermark");
	rd(8'hc0, 16'h0, "unmapped");
	wr(8'hb4, 16'h0200);
	rd(8'hb4, 16'h0200, "overrun rewrite");
	// keep the high mark below the drop test so no pause frame leaves early
	wr(8'hb2, 16'h0100);
	rd(8'hb2, 16'h0100, "high rewrite");
	cyc(1);
	i_rxq_free <= 16'h0200;
	cyc(3);
	#1 chk("rx drop at mark", 16'h1, 16'(o_rx_drop));
	cyc(1);
	i_rxq_free <= 16'h0201;
	cyc(3);
	#1 chk("rx drop above", 16'h0, 16'(o_rx_drop));
	cyc(1);
	i_rxq_free <= 16'hffff;
	wr(8'hb2, 16'h0c00);
	$display("test watermarks done");
	cyc(1);
	i_rxq_free <= 16'h0c00;
	wait_go;
	chk("xoff kind", 16'h1, 16'(o_tx_is_pause));
	chk("xoff time", 16'hffff, o_tx_pause_time);
	cyc(1);
	i_rxq_free <= 16'h13ff;
	cyc(1);
	g = n_go;
	cyc(200);
	chk("hysteresis", 16'h0, 16'(n_go - g));
	i_rxq_free <= 16'h1400;
	wait_go;
	chk("xon time", 16'h0, o_tx_pause_time);
	cyc(100);
	pause_in(16'h0002);
	cyc(100);
	rd(8'hb8, 16'h0001, "status paused");
	cyc(1);
	i_txq_pend <= 1'b1;
	pause_in(16'h0002);
	wait_go;
	chk("pause hold", 16'h1, 16'(n >= 250 && n <= 300));
	chk("normal kind", 16'h0, 16'(o_tx_is_pause));
	cyc(1);
	i_txq_pend <= 1'b0;
	$display("test flow control done");
	cyc(100);
	wr(8'hb6, 16'h0002);
	cyc(30);
	len <= 8'hc8;
	col_at <= 8'h96;
	i_txq_pend <= 1'b1;
	k = n_drop;
	wait_go;
	cyc(160);
	col_at <= 8'h0;
	i_txq_pend <= 1'b0;
	chk("late drop", 16'h1, 16'(n_drop - k));
	cyc(100);
	len <= 8'h20;
	col_at <= 8'h14;
	i_txq_pend <= 1'b1;
	g = n_go;
	wait_go;
	cyc(30);
	col_at <= 8'h0;
	wait_go;
	i_txq_pend <= 1'b0;
	cyc(2);
	chk("retry", 16'h2, 16'(n_go - g));
	chk("no drop", 16'h1, 16'(n_drop - k));
	chk("aborts", 16'h2, 16'(n_abt));
	$display("test collisions done");
	cyc(100);
	wr(8'hb6, 16'h0006);
	cyc(1);
	i_rxq_free <= 16'h0c00;
	cyc(10);
	#1 chk("bp on", 16'h1, 16'(o_bp_carrier));
	k = 0;
	repeat (2600) begin
		cyc(1);
		#1 k += int'(o_bp_carrier !== 1'b1);
	end
	chk("bp silent", 16'h1, 16'(k >= 25 && k < 60));
	cyc(1);
	i_txq_pend <= 1'b1;
	cyc(3);
	#1 chk("bp yield", 16'h0, 16'(o_bp_carrier));
	wait_go;
	cyc(1);
	i_txq_pend <= 1'b0;
	cyc(120);
	#1 chk("bp resume", 16'h1, 16'(o_bp_carrier));
	cyc(1);
	i_rxq_free <= 16'h1400;
	cyc(5);
	#1 chk("bp release", 16'h0, 16'(o_bp_carrier));
	$display("test backpressure done");
	final_report;
end
endmodule
`default_nettype wire
